// >>> verification/acpc_chk.sv
// Concurrent checks on the converter config block ports
`timescale 1ns/1ns
module acpc_chk (
  input wire logic                     sys_clk,      // Bus clock
  input wire logic                     arst_n,       // Async reset
  input wire acpc_pkg::acpc_bus_req_t  bus_req,      // Register request
  input wire logic [7:0]               bus_rdata,    // Read data
  input wire acpc_pkg::acpc_conv_ctl_t conv_ctl,     // Converter controls
  input wire acpc_pkg::acpc_pin_drv_t  port_drv,     // Port requests
  input wire logic [15:0]              pad_in,       // Pad levels
  input wire acpc_pkg::acpc_pin_drv_t  pad_drv,      // Pad controls
  input wire logic [15:0]              port_rd_data, // Port read levels
  input wire logic [15:0]              analog_sel    // Analog pins
);
  logic [1:0] live_reg; // Edges since release, covers the reset sync
  logic [3:0] age_reg;  // Cycles since the last config write
  logic [7:0] cfg_reg;  // Shadow of the config register
  logic       cfg_wr;
  logic       calm;     // Divider settled, no recent config change
  assign cfg_wr = bus_req.wr && bus_req.addr == 4'h0;
  assign calm   = age_reg == 4'hf;
  // Shadow and age counters
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      live_reg <= 2'h0;
      age_reg  <= 4'h0;
      cfg_reg  <= 8'h00;
    end else begin
      live_reg <= live_reg + {1'b0, live_reg != 2'h3};
      age_reg  <= cfg_wr ? 4'h0 : age_reg + {3'h0, !calm};
      cfg_reg  <= cfg_wr ? bus_req.wdata : cfg_reg;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (live_reg != 2'h3);
  sequence gap7_s;
    !conv_ctl.converter_clock [*7] ##1 conv_ctl.converter_clock;
  endsequence
  sequence gap1_s;
    !conv_ctl.converter_clock ##1 conv_ctl.converter_clock;
  endsequence
  AST_PIN_FORCE: assert property ((analog_sel & (pad_drv.drive_en |
    pad_drv.pull_en | pad_drv.drive | port_rd_data)) == 16'h0)
    else $error("disabled pin still active");
  AST_PIN_PASS: assert property (pad_drv.drive_en ==
    ($past(port_drv.drive_en) & ~analog_sel)) else $error("pin enable");
  AST_PORT_RD: assert property (port_rd_data ==
    ($past(pad_in) & ~analog_sel)) else $error("port read level");
  AST_LOW_MAP: assert property (bus_req.rd && bus_req.addr == 4'h1
    |=> bus_rdata == analog_sel[7:0]) else $error("low pin map");
  AST_MID_MAP: assert property (bus_req.rd && bus_req.addr == 4'h2
    |=> bus_rdata == analog_sel[15:8]) else $error("mid pin map");
  AST_CFG_MAP: assert property (
    bus_req.rd && bus_req.addr == 4'h0
    |=> {bus_rdata[7], bus_rdata[4], bus_rdata[3:2]} == conv_ctl[4:1])
    else $error("config copy");
  AST_DIV1: assert property (calm && cfg_reg[6:5] == 2'h0
    && cfg_reg[1:0] == 2'h0 |-> conv_ctl.converter_clock)
    else $error("bus clock tick missing");
  AST_DIV8: assert property (conv_ctl.converter_clock && calm
    && cfg_reg[6:5] == 2'h3 && cfg_reg[1:0] == 2'h0 |=> gap7_s)
    else $error("divide by eight spacing");
  AST_HALF: assert property (conv_ctl.converter_clock && calm
    && cfg_reg[6:5] == 2'h0 && cfg_reg[1:0] == 2'h1 |=> gap1_s)
    else $error("half bus clock spacing");
endmodule
bind acpc_top acpc_chk chk_u (.sys_clk(sys_clk), .arst_n(arst_n),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .conv_ctl(conv_ctl),
  .port_drv(port_drv), .pad_in(pad_in), .pad_drv(pad_drv),
  .port_rd_data(port_rd_data), .analog_sel(analog_sel));

// >>> verification/tb_acpc_top.sv
// Self-checking bench for the converter config block
`timescale 1ns/1ns
module tb_acpc_top;
  localparam logic [3:0]  AP = 4'h4;     // Internal tick period
  localparam logic [15:0] M  = 16'h8181; // Pins given to analog
  logic                     sys_clk;
  logic                     arst_n;
  acpc_pkg::acpc_bus_req_t  bus_req;
  logic [7:0]               bus_rdata;
  logic                     alt_clk_en;
  acpc_pkg::acpc_conv_ctl_t conv_ctl;
  acpc_pkg::acpc_pin_drv_t  port_drv;
  logic [15:0]              pad_in;
  acpc_pkg::acpc_pin_drv_t  pad_drv;
  logic [15:0]              port_rd_data;
  logic [15:0]              analog_sel;
  logic [1:0]               alt_cnt;
  int                       fail_count;
  int                       checks;
  int                       n;
  logic [7:0] cfgs [6] = '{8'h80, 8'h10, 8'h04, 8'h08, 8'hf9, 8'h00};
  logic [7:0] pcfg [8] = '{8'h00, 8'h20, 8'h40, 8'h60,
                           8'h01, 8'h02, 8'h03, 8'h43};
  int         pexp [8] = '{1, 2, 4, 8, 2, 3, AP, 4 * AP};
  acpc_top #(.ASYNC_PERIOD(AP)) dut_u (.sys_clk(sys_clk), .arst_n(arst_n),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .alt_clk_en(alt_clk_en),
    .conv_ctl(conv_ctl), .port_drv(port_drv), .pad_in(pad_in),
    .pad_drv(pad_drv), .port_rd_data(port_rd_data),
    .analog_sel(analog_sel));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Alternate clock ticks one cycle in three, so its rate differs from all
  always @(posedge sys_clk) begin
    alt_cnt    <= (alt_cnt == 2'h2) ? 2'h0 : alt_cnt + 2'h1;
    alt_clk_en <= (alt_cnt == 2'h2);
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Strobes are raised one edge after the last one dropped
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1 chk({8'h00, bus_rdata}, {8'h00, e});
  endtask
  task automatic next_pulse;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1 n++;
    end while (conv_ctl.converter_clock !== 1'b1 && n < 40);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Watchdog: about twenty-five times the planned run length
  initial begin
    #400000;
    fail_count++;
    complete_run();
  end
  initial begin
    {bus_req, port_drv, pad_in, alt_cnt, alt_clk_en} = '0;
    {fail_count, checks, n} = '0;
    arst_n = 1'b0;
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rdc(4'h0, 8'h00);
    rdc(4'h1, 8'h00);
    rdc(4'h2, 8'h00);
    $display("reset values done");
    foreach (cfgs[i]) begin
      wr(4'h0, cfgs[i]);
      rdc(4'h0, cfgs[i]);
      chk(conv_ctl[4:1],
          {cfgs[i][7], cfgs[i][4], cfgs[i][3:2]});
    end
    $display("config fields done");
    // Settle after each change, then time the gap between two ticks
    foreach (pcfg[i]) begin
      wr(4'h0, pcfg[i]);
      repeat (20) @(posedge sys_clk);
      next_pulse();
      next_pulse();
      chk(n[15:0], pexp[i][15:0]);
      repeat (10) @(posedge sys_clk);
    end
    $display("clock derivation done");
    @(posedge sys_clk);
    port_drv <= '{drive: 16'h5a5a, drive_en: 16'hffff, pull_en: 16'hc3c3};
    pad_in   <= 16'ha5a5;
    wr(4'h1, M[7:0]);
    wr(4'h2, M[15:8]);
    repeat (2) @(posedge sys_clk);
    #1 chk(analog_sel, M);
    chk(pad_drv.drive_en, ~M);
    chk(pad_drv.pull_en, 16'hc3c3 & ~M);
    chk(pad_drv.drive, 16'h5a5a & ~M);
    chk(port_rd_data, 16'ha5a5 & ~M);
    wr(4'h5, 8'hff);
    rdc(4'h5, 8'h00);
    rdc(4'h1, M[7:0]);
    rdc(4'h2, M[15:8]);
    $display("pin control done");
    complete_run();
  end
endmodule

// >>> verilog/acpc_params.svh
// Offsets, reset values and timing counts of the converter config block
`ifndef ACPC_PARAMS_SVH
`define ACPC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register bus
// ----------------------------------------------------------------------
`define ACPC_ADDR_W        4
`define ACPC_DATA_W        8
`define ACPC_OFS_CFG       4'h0
`define ACPC_OFS_PIN_LOW   4'h1
`define ACPC_OFS_PIN_MID   4'h2
`define ACPC_RDATA_IDLE    8'h00

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ACPC_CFG_RESET     8'h00
`define ACPC_PIN_RESET     8'h00

// ----------------------------------------------------------------------
// Pins and clock generation
// ----------------------------------------------------------------------
`define ACPC_PIN_GROUP     8
`define ACPC_NUM_PINS      16
`define ACPC_DIV_CNT_W     3
`define ACPC_ASYNC_CNT_W   4
`define ACPC_ASYNC_PERIOD  4'h4

`endif

// >>> verilog/acpc_pkg.sv
// Types shared by the converter config and pin control block
package acpc_pkg;

  // ----------------------------------------------------------------------
  // Mode and clock source codes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    res_8bit  = 2'h0,
    res_12bit = 2'h1,
    res_10bit = 2'h2,
    res_rsvd  = 2'h3
  } acpc_mode_t;

  typedef enum logic [1:0] {
    src_bus      = 2'h0,
    src_bus_half = 2'h1,
    src_alt      = 2'h2,
    src_async    = 2'h3
  } acpc_clk_src_t;

  // ----------------------------------------------------------------------
  // Register layouts, most significant field first
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic          low_power_select;
    logic [1:0]    clock_divide_field;
    logic          long_sample_select;
    acpc_mode_t    conv_mode;
    acpc_clk_src_t input_clock_select;
  } acpc_cfg_t;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } acpc_bus_req_t;

  typedef struct packed {
    logic [15:0] drive;
    logic [15:0] drive_en;
    logic [15:0] pull_en;
  } acpc_pin_drv_t;

  typedef struct packed {
    logic        low_power_select;
    logic        long_sample_select;
    acpc_mode_t  conv_mode;
    logic        converter_clock;
  } acpc_conv_ctl_t;

  typedef struct packed {
    acpc_cfg_t      cfg;
    logic [7:0]     pin_low;
    logic [7:0]     pin_mid;
    logic [7:0]     rdata;
    logic           half_phase;
    logic [3:0]     async_cnt;
    logic           async_en;
    logic [2:0]     div_cnt;
    acpc_conv_ctl_t conv;
    acpc_pin_drv_t  pad;
    logic [15:0]    port_rd;
    logic [15:0]    analog_sel;
  } acpc_state_t;

endpackage

// >>> verilog/acpc_top.sv
// Converter configuration register, clock derivation and pin control
`timescale 1ns/1ns
`include "acpc_params.svh"

module acpc_top #(
  parameter logic [3:0] ASYNC_PERIOD = `ACPC_ASYNC_PERIOD
) (
  input  wire logic                   sys_clk,       // Bus clock
  input  wire logic                   arst_n,        // Async reset
  input  wire acpc_pkg::acpc_bus_req_t bus_req,      // Register request
  output logic [7:0]                  bus_rdata,     // Read data
  input  wire logic                   alt_clk_en,    // Alternate clock tick
  output acpc_pkg::acpc_conv_ctl_t    conv_ctl,      // Converter controls
  input  wire acpc_pkg::acpc_pin_drv_t port_drv,     // Port I/O requests
  input  wire logic [15:0]            pad_in,        // Pad input levels
  output acpc_pkg::acpc_pin_drv_t     pad_drv,       // Pad drive controls
  output logic [15:0]                 port_rd_data,  // Port read levels
  output logic [15:0]                 analog_sel     // Pins given to analog
);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_sync_reg;

  // Release is synchronised so all state leaves reset on one edge
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Per-pin steering
  // ----------------------------------------------------------------------
  acpc_pkg::acpc_state_t state_reg;
  acpc_pkg::acpc_state_t state_next;
  logic [15:0]           pin_dis;
  logic [15:0]           drive_w;
  logic [15:0]           drive_en_w;
  logic [15:0]           pull_en_w;
  logic [15:0]           port_rd_w;

  assign pin_dis = {state_reg.pin_mid, state_reg.pin_low};

  genvar gi;
  generate
    for (gi = 0; gi < `ACPC_NUM_PINS; gi++) begin : g_pin
      // Bit gi of the low register is channel gi, mid register is 8+k
      // Both registers are concatenated above, so one loop serves all
      assign drive_w[gi]    = pin_dis[gi] ? 1'b0 : port_drv.drive[gi];
      assign drive_en_w[gi] = pin_dis[gi] ? 1'b0 : port_drv.drive_en[gi];
      assign pull_en_w[gi]  = pin_dis[gi] ? 1'b0 : port_drv.pull_en[gi];
      assign port_rd_w[gi]  = pin_dis[gi] ? 1'b0 : pad_in[gi];
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  logic       src_tick;
  logic [2:0] div_last;

  always_comb begin
    state_next = state_reg;
    src_tick   = 1'b0;
    div_last   = 3'h0;

    // Register writes; reserved mode code is stored as written
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        `ACPC_OFS_CFG: begin
          state_next.cfg = acpc_pkg::acpc_cfg_t'(bus_req.wdata);
        end
        `ACPC_OFS_PIN_LOW: begin
          state_next.pin_low = bus_req.wdata;
        end
        `ACPC_OFS_PIN_MID: begin
          state_next.pin_mid = bus_req.wdata;
        end
        default: begin
        end
      endcase
    end

    // Read data stands in the cycle after the strobe only
    state_next.rdata = `ACPC_RDATA_IDLE;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        `ACPC_OFS_CFG: begin
          state_next.rdata = state_reg.cfg;
        end
        `ACPC_OFS_PIN_LOW: begin
          state_next.rdata = state_reg.pin_low;
        end
        `ACPC_OFS_PIN_MID: begin
          state_next.rdata = state_reg.pin_mid;
        end
        default: begin
          state_next.rdata = `ACPC_RDATA_IDLE;
        end
      endcase
    end

    // Internal asynchronous clock stand-in: a free-running tick
    state_next.async_en = 1'b0;
    if (state_reg.async_cnt >= (ASYNC_PERIOD - 4'h1)) begin
      state_next.async_cnt = 4'h0;
      state_next.async_en  = 1'b1;
    end else begin
      state_next.async_cnt = state_reg.async_cnt + 4'h1;
    end

    // Bus clock halved runs all the time so switching is glitch free
    state_next.half_phase = ~state_reg.half_phase;

    // Input clock source pick
    unique case (state_reg.cfg.input_clock_select)
      acpc_pkg::src_bus:      src_tick = 1'b1;
      acpc_pkg::src_bus_half: src_tick = state_reg.half_phase;
      acpc_pkg::src_alt:      src_tick = alt_clk_en;
      acpc_pkg::src_async:    src_tick = state_reg.async_en;
    endcase

    // Divider: terminal count is ratio minus one
    div_last = 3'((4'h1 << state_reg.cfg.clock_divide_field) - 4'h1);
    state_next.conv.converter_clock = 1'b0;
    if (src_tick) begin
      if (state_reg.div_cnt >= div_last) begin
        state_next.div_cnt              = 3'h0;
        state_next.conv.converter_clock = 1'b1;
      end else begin
        state_next.div_cnt = state_reg.div_cnt + 3'h1;
      end
    end

    // Converter controls follow the stored configuration
    state_next.conv.low_power_select   = state_reg.cfg.low_power_select;
    state_next.conv.long_sample_select =
      state_reg.cfg.long_sample_select;
    state_next.conv.conv_mode          = state_reg.cfg.conv_mode;

    // Pad side registered; one cycle of lag is harmless for static pins
    state_next.pad.drive    = drive_w;
    state_next.pad.drive_en = drive_en_w;
    state_next.pad.pull_en  = pull_en_w;
    state_next.port_rd      = port_rd_w;
    state_next.analog_sel   = pin_dis;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Zero reset also picks the bus clock as converter source
  always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      state_reg         <= '0;
      state_reg.cfg     <= `ACPC_CFG_RESET;
      state_reg.pin_low <= `ACPC_PIN_RESET;
      state_reg.pin_mid <= `ACPC_PIN_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------------
  assign bus_rdata    = state_reg.rdata;
  assign conv_ctl     = state_reg.conv;
  assign pad_drv      = state_reg.pad;
  assign port_rd_data = state_reg.port_rd;
  assign analog_sel   = state_reg.analog_sel;

endmodule
